// *** common/ajso_pkg.sv ***
// constants, register indices and types for the audio jack switch override block
// assumes a 50 MHz system clock and an axi4-lite register bus with 32-bit data
package ajso_pkg;
   // clock and timing
   localparam int CLK_KHZ = 50_000;
   localparam int DEBOUNCE_MS = 90;
   localparam int DETECT_US = 1000;
   localparam int DEBOUNCE_CYCLES_DEF = DEBOUNCE_MS * CLK_KHZ;
   localparam int DETECT_CYCLES_DEF = (DETECT_US * CLK_KHZ + 999) / 1000;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

   // register bus
   localparam int ADDR_W = 6;
   localparam logic [3:0] IDX_DEVICE_ID = 4'h0;
   localparam logic [3:0] IDX_INTERRUPT = 4'h1;
   localparam logic [3:0] IDX_SETTINGS = 4'h4;
   localparam logic [3:0] IDX_SWITCH_CTRL1 = 4'h7;
   localparam logic [3:0] IDX_SWITCH_CTRL2 = 4'h8;
   localparam logic [3:0] IDX_SWITCH_STAT1 = 4'h9;
   localparam logic [3:0] IDX_SWITCH_STAT2 = 4'ha;
   localparam logic [3:0] IDX_ACCESSORY = 4'hb;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // device settings fields
   localparam int SET_OVERRIDE_BIT = 6;
   localparam int SET_AUTO_BIT = 5;
   localparam int SET_TRIG_BIT = 4;
   localparam int SET_RADIO_BIT = 3;
   localparam int SET_DEB_MSB = 2;
   localparam logic [7:0] SETTINGS_RESET = 8'h23;

   // interrupt and accessory status fields
   localparam int INT_DC_BIT = 1;
   localparam int ACC_INS_BIT = 3;

   // accessory type code on the detector pins
   localparam logic [1:0] TYPE_3POLE = 2'h1;
   localparam logic [1:0] TYPE_4STD = 2'h2;
   localparam logic [1:0] TYPE_OMTP = 2'h3;

   // switch word: ctrl1 = sleeve/ring2 gnd fets, depletion fets, s2, s1
   typedef struct packed {
      logic [5:0] ctrl1;
      logic [3:0] ctrl2;
   } ajso_sw_t;

   typedef struct packed {
      logic four_std;
      logic omtp;
      logic three_pole;
   } ajso_acc_t;

   localparam logic [5:0] SW1_DEPLETION_MASK = 6'h0c;
   localparam ajso_sw_t SW_NO_INSERT = '{ctrl1: 6'h0c, ctrl2: 4'h0};
   localparam ajso_sw_t SW_3POLE = '{ctrl1: 6'h3c, ctrl2: 4'h0};
   localparam ajso_sw_t SW_4STD = '{ctrl1: 6'h2d, ctrl2: 4'h4};
   localparam ajso_sw_t SW_OMTP = '{ctrl1: 6'h1e, ctrl2: 4'h8};

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DEBOUNCE,
      ST_DETECT,
      ST_INSERTED
   } ajso_state_t;
endpackage : ajso_pkg

// *** rtl/ajso_top.sv ***
// switch arbitration between detection result and host switch registers
// assumes jack sense and type code pins are asynchronous, one 50 MHz clock
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - writing one to override bit 6 of settings enters host switch override
// - override leaves insertion sensing and type detection running unchanged
// - during type detection switch outputs hold; pending values apply after
// - during debounce switch outputs hold as well
// - otherwise override drives outputs from host switch registers at once
// - clearing override drives outputs to latest detection result at once
// - with no detection run and radio pass-through off, clearing override gives the no-insertion setting
// - sleep is never asserted while override is set
// - auto detect off and no trigger: insertion changes no type flag, and no switch unless radio pass-through is on
// - software trigger starts detection updating type flags, even under override
// - after detection under override, outputs stay at host values
// - software trigger reads back zero once insertion has been processed
// - detection runs on auto enable or trigger; three-pole gives three-pole setting
// - under override all-ones host values reach outputs, type flags untouched
// - radio pass-through turns depletion switches off while accessory inserted and override clear
// - sleep when no accessory and override clear; insertion wakes detection
// - detection-complete flag set at end of every detection unless a same-cycle interrupt read finds it already set
module ajso_top
   import ajso_pkg::*;
#(
   parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYCLES_DEF),
   parameter logic [CNT_W-1:0] DETECT_CYCLES = CNT_W'(DETECT_CYCLES_DEF),
   // identity value is arbitrary
   parameter logic [7:0] DEVICE_ID = 8'h5a
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // jack pins
   input wire logic jack_sense,
   input wire logic [1:0] type_code,
   // switch drive and power state
   output ajso_sw_t switch_out,
   output logic sleep_mode
);

   typedef struct packed {
      logic [2:0] sense_sync;
      logic [5:0] type_sync;
      logic present;
      logic [1:0] type_now;
      ajso_state_t state;
      logic [CNT_W-1:0] cnt;
      logic override;
      logic auto_en;
      logic trig;
      logic radio_passthrough_enable;
      logic [SET_DEB_MSB:0] deb_sel;
      ajso_sw_t host;
      ajso_sw_t detected;
      ajso_acc_t acc;
      logic det_done;
      ajso_sw_t sw;
      logic sleep;
      logic aw_hold;
      logic [3:0] aw_idx;
      logic w_hold;
      logic [7:0] w_byte;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ajso_regs_t;

   ajso_regs_t r;
   ajso_regs_t next_r;

   // byte address index field and switch register widths
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 5;
   localparam int SW1_MSB = 5;
   localparam int SW2_MSB = 3;
   localparam int ACC_MSB = $bits(ajso_acc_t) - 1;

   function automatic ajso_sw_t type_cfg(input logic [1:0] code);
      ajso_sw_t cfg;
      cfg = SW_NO_INSERT;
      unique case (code)
         TYPE_3POLE: cfg = SW_3POLE;
         TYPE_4STD: cfg = SW_4STD;
         TYPE_OMTP: cfg = SW_OMTP;
         default: cfg = SW_NO_INSERT;
      endcase
      return cfg;
   endfunction : type_cfg

   logic busy;
   logic wr_fire;
   logic rd_fire;
   logic [3:0] rd_idx;
   logic [7:0] rd_byte;
   logic rd_ok;
   ajso_sw_t auto_cfg;

   always_comb begin
      next_r = r;
      busy = (r.state == ST_DEBOUNCE) || (r.state == ST_DETECT);
      wr_fire = r.aw_hold && r.w_hold && !r.bvalid;
      rd_fire = s_axi_arvalid && r.arready;
      rd_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      auto_cfg = r.detected;

      // pin synchronisers, change accepted when stages two and three agree
      next_r.sense_sync = {r.sense_sync[1:0], jack_sense};
      next_r.type_sync = {r.type_sync[3:0], type_code};
      if (r.sense_sync[1] == r.sense_sync[2]) begin
         next_r.present = r.sense_sync[2];
      end
      if (r.type_sync[3:2] == r.type_sync[5:4]) begin
         next_r.type_now = r.type_sync[5:4];
      end

      // insertion, debounce and detection sequence
      next_r.cnt = r.cnt + CNT_ONE;
      unique case (r.state)
         ST_IDLE: begin
            next_r.cnt = '0;
            if (r.present) begin
               next_r.state = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (!r.present) begin
               next_r.state = ST_IDLE;
               next_r.cnt = '0;
            end else if (r.cnt == DEBOUNCE_CYCLES - CNT_ONE) begin
               next_r.cnt = '0;
               next_r.trig = 1'b0;
               if (r.auto_en || r.trig) begin
                  next_r.state = ST_DETECT;
               end else begin
                  next_r.state = ST_INSERTED;
               end
            end
         end
         ST_DETECT: begin
            if (!r.present) begin
               next_r.state = ST_IDLE;
               next_r.cnt = '0;
            end else if (r.cnt == DETECT_CYCLES - CNT_ONE) begin
               next_r.state = ST_INSERTED;
               next_r.cnt = '0;
               next_r.detected = type_cfg(r.type_now);
               next_r.acc.three_pole = (r.type_now == TYPE_3POLE);
               next_r.acc.four_std = (r.type_now == TYPE_4STD);
               next_r.acc.omtp = (r.type_now == TYPE_OMTP);
               next_r.det_done = 1'b1;
            end
         end
         ST_INSERTED: begin
            next_r.cnt = '0;
            if (!r.present) begin
               next_r.state = ST_IDLE;
            end else if (r.trig) begin
               next_r.state = ST_DETECT;
               next_r.trig = 1'b0;
            end
         end
      endcase

      // removal forgets the previous detection
      if (!r.present && r.state != ST_IDLE) begin
         next_r.detected = SW_NO_INSERT;
         next_r.acc = '0;
         next_r.det_done = 1'b0;
      end

      // radio pass-through drops the depletion switches once inserted
      if (r.radio_passthrough_enable && r.state != ST_IDLE) begin
         auto_cfg.ctrl1 = r.detected.ctrl1 & ~SW1_DEPLETION_MASK;
      end

      // registered switch selector, frozen while debounce or detection runs
      if (!busy) begin
         if (r.override) begin
            next_r.sw = r.host;
         end else begin
            next_r.sw = auto_cfg;
         end
      end

      // write address and data taken in either order
      if (s_axi_awvalid && r.awready) begin
         next_r.aw_hold = 1'b1;
         next_r.aw_idx = s_axi_awaddr[IDX_MSB:IDX_LSB];
         next_r.awready = 1'b0;
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.w_hold = 1'b1;
         next_r.w_byte = s_axi_wdata[7:0];
         next_r.w_lane0 = s_axi_wstrb[0];
         next_r.wready = 1'b0;
      end
      // response only once both address and data are held
      if (wr_fire) begin
         next_r.aw_hold = 1'b0;
         next_r.w_hold = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_OKAY;
         unique case (r.aw_idx)
            IDX_SETTINGS: begin
               if (r.w_lane0) begin
                  next_r.override = r.w_byte[SET_OVERRIDE_BIT];
                  next_r.auto_en = r.w_byte[SET_AUTO_BIT];
                  // write lands after the hardware clear, so software wins
                  next_r.trig = r.w_byte[SET_TRIG_BIT];
                  next_r.radio_passthrough_enable = r.w_byte[SET_RADIO_BIT];
                  next_r.deb_sel = r.w_byte[SET_DEB_MSB:0];
               end
            end
            IDX_SWITCH_CTRL1: begin
               if (r.w_lane0) begin
                  next_r.host.ctrl1 = r.w_byte[SW1_MSB:0];
               end
            end
            IDX_SWITCH_CTRL2: begin
               if (r.w_lane0) begin
                  next_r.host.ctrl2 = r.w_byte[SW2_MSB:0];
               end
            end
            IDX_DEVICE_ID, IDX_INTERRUPT, IDX_SWITCH_STAT1, IDX_SWITCH_STAT2,
            IDX_ACCESSORY: begin
               next_r.bresp = RESP_OKAY;
            end
            default: begin
               next_r.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready = 1'b1;
      end

      // read path, detection-complete clears on read, a set in the same cycle wins only when the flag was clear
      unique case (rd_idx)
         IDX_DEVICE_ID: rd_byte = DEVICE_ID;
         IDX_INTERRUPT: rd_byte[INT_DC_BIT] = r.det_done;
         IDX_SETTINGS: begin
            rd_byte[SET_OVERRIDE_BIT] = r.override;
            rd_byte[SET_AUTO_BIT] = r.auto_en;
            rd_byte[SET_TRIG_BIT] = r.trig;
            rd_byte[SET_RADIO_BIT] = r.radio_passthrough_enable;
            rd_byte[SET_DEB_MSB:0] = r.deb_sel;
         end
         IDX_SWITCH_CTRL1: rd_byte[SW1_MSB:0] = r.host.ctrl1;
         IDX_SWITCH_CTRL2: rd_byte[SW2_MSB:0] = r.host.ctrl2;
         IDX_SWITCH_STAT1: rd_byte[SW1_MSB:0] = r.sw.ctrl1;
         IDX_SWITCH_STAT2: rd_byte[SW2_MSB:0] = r.sw.ctrl2;
         IDX_ACCESSORY: begin
            rd_byte[ACC_INS_BIT] = (r.state == ST_INSERTED) || (r.state == ST_DETECT);
            rd_byte[ACC_MSB:0] = r.acc;
         end
         default: rd_ok = 1'b0;
      endcase
      if (rd_fire) begin
         next_r.arready = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rdata = {24'h000000, rd_byte};
         next_r.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
         if (rd_idx == IDX_INTERRUPT && next_r.det_done == r.det_done) begin
            next_r.det_done = 1'b0;
         end
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
         next_r.arready = 1'b1;
      end

      // sleep follows the next state, so it never overlaps override
      next_r.sleep = (next_r.state == ST_IDLE) && !next_r.present && !next_r.override;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.auto_en <= SETTINGS_RESET[SET_AUTO_BIT];
         r.override <= SETTINGS_RESET[SET_OVERRIDE_BIT];
         r.trig <= SETTINGS_RESET[SET_TRIG_BIT];
         r.radio_passthrough_enable <= SETTINGS_RESET[SET_RADIO_BIT];
         r.deb_sel <= SETTINGS_RESET[SET_DEB_MSB:0];
         r.detected <= SW_NO_INSERT;
         r.sw <= SW_NO_INSERT;
         r.sleep <= 1'b1;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign switch_out = r.sw;
   assign sleep_mode = r.sleep;

endmodule : ajso_top

// *** tb/ajso_properties.sv ***
// port assertions for the jack switch override block
// assumes debounce and detect spans of at least 8 and 4 cycles
`timescale 1ns/1ps
module ajso_properties
   import ajso_pkg::*;
(
   // clock, reset and register bus
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // jack and switches
   input wire logic jack_sense,
   input wire ajso_sw_t switch_out,
   input wire logic sleep_mode
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ins_seq;
      $rose(jack_sense) ##1 jack_sense [*6];
   endsequence
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_reset_state: assert property ($rose(aresetn) |->
      switch_out == SW_NO_INSERT && sleep_mode)
      else $error("outputs not at reset state");
   a_switch_frozen: assert property (ins_seq |-> $stable(switch_out) [*8])
      else $error("switch moved during debounce");
   a_sleep_wake: assert property (jack_sense [*8] |=> !sleep_mode)
      else $error("sleep held with accessory present");
   a_write_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   a_write_busy: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready not dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data missing");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not released");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == 4'hc
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule : ajso_properties

// *** tb/ajso_jack_model.sv ***
// accessory in the jack: drives sense and detector type pins
// assumes plug and kind change just after a clock edge
`timescale 1ns/1ps
module ajso_jack_model
   import ajso_pkg::*;
(
   // bench control and jack pins
   input wire logic aclk,
   input wire logic plug,
   input wire logic [1:0] kind,
   output logic jack_sense,
   output logic [1:0] type_code
);
   initial {jack_sense, type_code} = 3'h0;
   // detector pins wander while nothing is plugged
   always @(posedge aclk) begin
      jack_sense <= plug;
      type_code <= plug ? kind : ~type_code;
   end
endmodule : ajso_jack_model

// *** tb/audio_jack_switch_override_test.sv ***
// self-checking bench for the jack switch override block
// assumes the jack model on the pins and the checker bound at the foot
`timescale 1ns/1ps
module audio_jack_switch_override_test
   import ajso_pkg::*;
;
   logic aclk = '0, aresetn = '0, plug = '0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, jack_sense, sleep_mode;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, type_code, kind = 2'h0;
   ajso_sw_t switch_out;
   int fails = 0, n_compared = 0;
   logic [15:0] lfsr = 16'h65fb;
   always #10 aclk = ~aclk;
   ajso_top #(.DEBOUNCE_CYCLES(24'h000008), .DETECT_CYCLES(24'h000004)) i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .jack_sense, .type_code,
      .switch_out, .sleep_mode);
   ajso_jack_model i_jack (.aclk, .plug, .kind, .jack_sense, .type_code);
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   function automatic ajso_sw_t cfg_of(input logic [1:0] k, input logic radio);
      ajso_sw_t c;
      c = (k == TYPE_3POLE) ? SW_3POLE : (k == TYPE_4STD) ? SW_4STD : SW_OMTP;
      if (radio) c.ctrl1 = c.ctrl1 & ~SW1_DEPLETION_MASK;
      return c;
   endfunction : cfg_of
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("write response", (idx == 4'hf) ? RESP_SLVERR : RESP_OKAY, s_axi_bresp);
   endtask : wr
   task automatic rd(input string what, input logic [3:0] idx, input logic [7:0] exp);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(what, {24'h0, exp}, s_axi_rdata);
      chk("read response", (idx == 4'hc) ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
   endtask : rd
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (5000) @(posedge aclk);
      fails++;
      test_done;
   end
   initial begin
      logic [1:0] k;
      logic r, ov;
      logic [7:0] f;
      ajso_sw_t prev;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd("settings", IDX_SETTINGS, 8'h23);
      rd("status", IDX_SWITCH_STAT1, 8'h0c);
      rd("unmapped", 4'hc, 8'h00);
      wr(4'hf, 8'h00);
      wr(IDX_SETTINGS, 8'h03);
      kind <= TYPE_3POLE;
      plug <= 1'b1;
      repeat (40) @(posedge aclk);
      chk("switch", SW_NO_INSERT, switch_out);
      rd("accessory", IDX_ACCESSORY, 8'h08);
      wr(IDX_SWITCH_CTRL1, 8'hff);
      wr(IDX_SWITCH_CTRL2, 8'hff);
      wr(IDX_SETTINGS, 8'h43);
      repeat (3) @(posedge aclk);
      chk("switch", 10'h3ff, switch_out);
      chk("sleep", 1'b0, sleep_mode);
      rd("accessory", IDX_ACCESSORY, 8'h08);
      wr(IDX_SETTINGS, 8'h03);
      repeat (3) @(posedge aclk);
      chk("switch", SW_NO_INSERT, switch_out);
      wr(IDX_SETTINGS, 8'h43);
      wr(IDX_SETTINGS, 8'h53);
      repeat (12) @(posedge aclk);
      rd("accessory", IDX_ACCESSORY, 8'h09);
      rd("settings", IDX_SETTINGS, 8'h43);
      rd("interrupt", IDX_INTERRUPT, 8'h02);
      rd("interrupt", IDX_INTERRUPT, 8'h00);
      chk("switch", 10'h3ff, switch_out);
      wr(IDX_SETTINGS, 8'h03);
      repeat (3) @(posedge aclk);
      chk("switch", SW_3POLE, switch_out);
      plug <= 1'b0;
      repeat (20) @(posedge aclk);
      chk("switch", SW_NO_INSERT, switch_out);
      chk("sleep", 1'b1, sleep_mode);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         k = 2'(i % 3) + 2'h1;
         ov = (i == 5);
         r = lfsr[1] & ~ov;
         f = (k == TYPE_3POLE) ? 8'h09 : (k == TYPE_OMTP) ? 8'h0a : 8'h0c;
         prev = ov ? ajso_sw_t'(10'h3ff) : SW_NO_INSERT;
         wr(IDX_SETTINGS, {1'b0, ov, lfsr[0], ~lfsr[0], r, 3'h3});
         chk("sleep", !ov, sleep_mode);
         kind <= k;
         plug <= 1'b1;
         repeat (8) @(posedge aclk);
         chk("switch", prev, switch_out);
         if (ov) wr(IDX_SWITCH_CTRL1, 8'h15);
         repeat (2) @(posedge aclk);
         chk("switch", prev, switch_out);
         repeat (30) @(posedge aclk);
         prev = ov ? ajso_sw_t'({6'h15, 4'hf}) : cfg_of(k, r);
         chk("switch", prev, switch_out);
         rd("accessory", IDX_ACCESSORY, f);
         plug <= 1'b0;
         repeat (20) @(posedge aclk);
      end
      test_done;
   end
endmodule : audio_jack_switch_override_test
bind ajso_top ajso_properties i_props (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .jack_sense, .switch_out, .sleep_mode);
